// [logic/sac_consts.svh]
// Constants for the converter control block: offsets, fields, counts.
// Assumes one byte-wide register in the low byte of each 32-bit word.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// Register byte addresses
`define SAC_OFF_SELECT   8'h00
`define SAC_OFF_CTRL_A   8'h04
`define SAC_OFF_CTRL_B   8'h08
`define SAC_OFF_RES_LO   8'h0C
`define SAC_OFF_RES_HI   8'h10

// Channel select register fields
`define SAC_SEL_REF_HI   7
`define SAC_SEL_REF_LO   6
`define SAC_SEL_LJUST    5
// Control A fields
`define SAC_A_ON         7
`define SAC_A_GO         6
`define SAC_A_AUTO       5
`define SAC_A_FLAG       4
`define SAC_A_IRQ_ON     3
// Control B writable width
`define SAC_B_TRIG_W     3

// Channel code boundaries
`define SAC_CODE_LAST_SE 5'h07
`define SAC_CODE_LAST_10 5'h0F
`define SAC_CODE_LAST_DF 5'h1D
`define SAC_CODE_BANDGAP 5'h1E
`define SAC_CODE_GROUND  5'h1F

// Conversion lengths in converter clock cycles
`define SAC_LEN_FIRST    5'd25
`define SAC_LEN_NORMAL   5'd13

// Trigger source codes
`define SAC_TRG_FREE     3'h0
`define SAC_TRG_COMP     3'h1
`define SAC_TRG_EXT0     3'h2
`define SAC_TRG_T0_CMP   3'h3
`define SAC_TRG_T0_OVF   3'h4
`define SAC_TRG_T1_CMPB  3'h5
`define SAC_TRG_T1_OVF   3'h6
`define SAC_TRG_T1_CAPT  3'h7

// Bus responses
`define SAC_RESP_OKAY    2'h0
`define SAC_RESP_SLVERR  2'h2

`endif

// [logic/sac_pkg.sv]
// Types shared by the converter control block.
// Assumes the constants header is included by each user.
package sac_pkg;

  // Amplifier gain of the selected channel
  typedef enum logic [1:0] {
    SAC_GAIN_1X   = 2'h0,
    SAC_GAIN_10X  = 2'h1,
    SAC_GAIN_200X = 2'h2
  } sac_gain_t;

  // Controls presented to the analog multiplexer and core
  typedef struct packed {
    logic       power_on;      // Converter powered
    logic       diff;          // Differential pair selected
    sac_gain_t  gain;          // Amplifier gain
    logic [1:0] reference_sel; // Reference choice, 10 reserved
    logic [4:0] input_select;  // Channel code held for this conversion
  } sac_analog_t;

  // Peripheral flags usable as auto-trigger sources
  typedef struct packed {
    logic comparator;  // Comparator output
    logic ext_int0;    // External interrupt request 0
    logic t0_cmp;      // Timer0 compare match
    logic t0_ovf;      // Timer0 overflow
    logic t1_cmp_b;    // Timer1 compare B
    logic t1_ovf;      // Timer1 overflow
    logic t1_capt;     // Timer1 capture event
  } sac_trig_t;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b01,
    SAC_RUN  = 2'b10
  } sac_state_t;

endpackage

// [logic/sac_top.sv]
// Converter control: registers on AXI4-Lite, sequencing, trigger, result.
// Assumes trigger flags and the core result come from aclk-domain logic.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "sac_consts.svh"

module sac_top #(
  parameter int ADDR_W = 8                  // AXI address width
) (
  input  wire logic                 aclk,          // System clock, 40 MHz
  input  wire logic                 aresetn,       // Synchronous reset, low
  input  wire logic [ADDR_W-1:0]    awaddr,        // Write address
  input  wire logic                 awvalid,       // Write address valid
  output logic                      awready,       // Write address ready
  input  wire logic [31:0]          wdata,         // Write data
  input  wire logic [3:0]           wstrb,         // Write byte enables
  input  wire logic                 wvalid,        // Write data valid
  output logic                      wready,        // Write data ready
  output logic [1:0]                bresp,         // Write response
  output logic                      bvalid,        // Write response valid
  input  wire logic                 bready,        // Write response ready
  input  wire logic [ADDR_W-1:0]    araddr,        // Read address
  input  wire logic                 arvalid,       // Read address valid
  output logic                      arready,       // Read address ready
  output logic [31:0]               rdata,         // Read data
  output logic [1:0]                rresp,         // Read response
  output logic                      rvalid,        // Read data valid
  input  wire logic                 rready,        // Read data ready
  input  wire sac_pkg::sac_trig_t   trig_flags,    // Trigger source flags
  input  wire logic                 global_irq_on, // Processor global enable
  input  wire logic                 irq_ack,       // Vector taken, pulse
  output logic                      irq_req,       // Completion interrupt
  input  wire logic [9:0]           core_result,   // Core code, offset binary
  output sac_pkg::sac_analog_t      analog,        // Mux and core controls
  output logic                      conv_tick,     // Converter clock pulse
  output logic                      conv_start,    // Sample pulse at start
  output logic                      conv_init      // Start is the first one
);

  // Gain and differential decode of a channel code
  function automatic sac_pkg::sac_gain_t gain_of(input logic [4:0] code);
    if (code > `SAC_CODE_LAST_SE && code <= `SAC_CODE_LAST_10) begin
      gain_of = code[1] ? sac_pkg::SAC_GAIN_200X : sac_pkg::SAC_GAIN_10X;
    end else begin
      gain_of = sac_pkg::SAC_GAIN_1X;
    end
  endfunction

  function automatic logic is_diff(input logic [4:0] code);
    // Bandgap and ground are single-ended like the eight pins
    is_diff = code > `SAC_CODE_LAST_SE && code <= `SAC_CODE_LAST_DF;
  endfunction

  // Prescaler terminal count for a divider code
  function automatic logic [6:0] div_last(input logic [2:0] sel);
    logic [7:0] div;
    div = (sel < 3'h2) ? 8'h02 : 8'(8'h01 << sel);
    div_last = 7'(div - 8'h01);
  endfunction

  // Register state
  logic [1:0]  ref_sel_q;          // Software reference choice
  logic        left_justify_q;     // Result presentation
  logic [4:0]  input_select_q;     // Software channel choice
  logic        converter_on_q;     // Power and enable
  logic        auto_trigger_on_q;  // Auto-trigger enable
  logic        done_flag_q;        // Conversion-done flag
  logic        done_irq_on_q;      // Done interrupt enable
  logic [2:0]  clock_div_sel_q;    // Prescaler code
  logic [2:0]  trig_src_sel_q;     // Auto-trigger source
  logic [9:0]  result_q;           // Stored result, two's complement if diff
  logic        lock_q;             // Low byte read, high pending
  sac_pkg::sac_analog_t act_q;     // Selection held for this conversion

  // Sequencer state
  sac_pkg::sac_state_t state_q;    // Idle or converting
  logic [6:0]  pre_cnt_q;          // Prescaler count
  logic [4:0]  cyc_cnt_q;          // Converter cycles elapsed
  logic        first_q;            // Next start needs initialisation
  logic        free_run_q;         // Free-run chain started
  logic        trig_prev_q;        // Previous selected trigger level

  // Bus state
  logic              aw_hold_q;    // Address captured
  logic [ADDR_W-1:0] aw_addr_q;    // Captured write address
  logic              w_hold_q;     // Data captured
  logic [7:0]        w_byte_q;     // Captured low data byte
  logic              w_lane_q;     // Low byte lane enabled
  logic              bvalid_q;     // Response pending
  logic [1:0]        bresp_q;      // Response code
  logic              rvalid_q;     // Read data pending
  logic [31:0]       rdata_q;      // Read data
  logic [1:0]        rresp_q;      // Read response code

  // Write takes effect once both halves are held
  logic wr_go, wr_a, wr_b, wr_sel, rd_go; // Write strobes per register, read taken
  assign wr_go  = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_sel = wr_go && w_lane_q && aw_addr_q[7:0] == `SAC_OFF_SELECT;
  assign wr_a   = wr_go && w_lane_q && aw_addr_q[7:0] == `SAC_OFF_CTRL_A;
  assign wr_b   = wr_go && w_lane_q && aw_addr_q[7:0] == `SAC_OFF_CTRL_B;
  assign rd_go  = arvalid && arready;

  // Sequencer events
  logic busy, tick, finish;         // Converting, converter clock, last cycle
  logic on_next, auto_next, sw_go;  // Enables as this cycle's write leaves them
  logic trig_lvl, trig_edge, start; // Trigger level, its edge, conversion start
  assign busy    = state_q == sac_pkg::SAC_RUN;
  assign tick    = busy && pre_cnt_q == div_last(clock_div_sel_q);
  assign finish  = tick && cyc_cnt_q == 5'(( first_q ? `SAC_LEN_FIRST
                                                     : `SAC_LEN_NORMAL) - 5'd1);
  assign on_next = wr_a ? w_byte_q[`SAC_A_ON] : converter_on_q;
  assign auto_next = wr_a ? w_byte_q[`SAC_A_AUTO] : auto_trigger_on_q;
  // Writing zero to convert-go does nothing
  assign sw_go   = wr_a && w_byte_q[`SAC_A_GO];

  // Selected trigger level; free-running code has no level of its own
  always_comb begin
    unique case (trig_src_sel_q)
      `SAC_TRG_FREE:    trig_lvl = 1'b0;
      `SAC_TRG_COMP:    trig_lvl = trig_flags.comparator;
      `SAC_TRG_EXT0:    trig_lvl = trig_flags.ext_int0;
      `SAC_TRG_T0_CMP:  trig_lvl = trig_flags.t0_cmp;
      `SAC_TRG_T0_OVF:  trig_lvl = trig_flags.t0_ovf;
      `SAC_TRG_T1_CMPB: trig_lvl = trig_flags.t1_cmp_b;
      `SAC_TRG_T1_OVF:  trig_lvl = trig_flags.t1_ovf;
      `SAC_TRG_T1_CAPT: trig_lvl = trig_flags.t1_capt;
    endcase
  end
  // Edge also fires when a reselect lands on a high flag
  assign trig_edge = auto_trigger_on_q && trig_lvl && !trig_prev_q;

  // Start from software, trigger edge, or free-run chaining
  assign start = on_next && (state_q == sac_pkg::SAC_IDLE) &&
                 (sw_go || trig_edge || free_run_q);

  // Previous trigger level, tracked even while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_lvl;
    end
  end

  // Conversion state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sac_pkg::SAC_IDLE;
    end else begin
      unique case (state_q)
        sac_pkg::SAC_IDLE: begin
          if (start) begin
            state_q <= sac_pkg::SAC_RUN;
          end
        end
        sac_pkg::SAC_RUN: begin
          // Switching off before the finish cycle aborts without a result
          if (!on_next || finish) begin
            state_q <= sac_pkg::SAC_IDLE;
          end
        end
        default: state_q <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // Prescaler and cycle counter, restarted per conversion for alignment
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) begin
      pre_cnt_q <= 7'h00;
      cyc_cnt_q <= 5'h00;
    end else if (tick) begin
      pre_cnt_q <= 7'h00;
      cyc_cnt_q <= 5'(cyc_cnt_q + 5'd1);
    end else begin
      pre_cnt_q <= 7'(pre_cnt_q + 7'd1);
    end
  end

  // Initialisation pending after each enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= 1'b0;
    end else if (!converter_on_q && on_next) begin
      first_q <= 1'b1;
    end else if (finish) begin
      first_q <= 1'b0;
    end
  end

  // Free-run chain; next auto value, so one write can enable and go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_run_q <= 1'b0;
    end else if (!on_next || !auto_next || trig_src_sel_q != `SAC_TRG_FREE) begin
      free_run_q <= 1'b0;
    end else if (start) begin
      free_run_q <= 1'b1;
    end
  end

  // Selection held while converting, taken from software when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= '0;
    end else if (!busy || finish) begin
      act_q.input_select  <= input_select_q;
      act_q.reference_sel <= ref_sel_q;
      act_q.diff          <= is_diff(input_select_q);
      act_q.gain          <= gain_of(input_select_q);
    end
  end
  always_comb begin
    analog          = act_q;
    analog.power_on = converter_on_q;
  end
  assign conv_tick  = tick;
  assign conv_start = start;
  assign conv_init  = start && (first_q || !converter_on_q);

  // Software-written control bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_sel_q         <= 2'h0;
      left_justify_q    <= 1'b0;
      input_select_q    <= 5'h00;
      converter_on_q    <= 1'b0;
      auto_trigger_on_q <= 1'b0;
      done_irq_on_q     <= 1'b0;
      clock_div_sel_q   <= 3'h0;
      trig_src_sel_q    <= 3'h0;
    end else begin
      if (wr_sel) begin
        ref_sel_q      <= w_byte_q[`SAC_SEL_REF_HI:`SAC_SEL_REF_LO];
        left_justify_q <= w_byte_q[`SAC_SEL_LJUST];
        input_select_q <= w_byte_q[4:0];
      end
      if (wr_a) begin
        converter_on_q    <= w_byte_q[`SAC_A_ON];
        auto_trigger_on_q <= w_byte_q[`SAC_A_AUTO];
        done_irq_on_q     <= w_byte_q[`SAC_A_IRQ_ON];
        clock_div_sel_q   <= w_byte_q[2:0];
      end
      if (wr_b) begin
        // Reserved bits are not stored and read zero
        trig_src_sel_q <= w_byte_q[`SAC_B_TRIG_W-1:0];
      end
    end
  end

  // Done flag: set wins over vector and write-one clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
    end else if (finish) begin
      done_flag_q <= 1'b1;
    end else if (irq_ack || (wr_a && w_byte_q[`SAC_A_FLAG])) begin
      done_flag_q <= 1'b0;
    end
  end
  assign irq_req = done_flag_q && done_irq_on_q && global_irq_on;

  // Result store, held while the pair is locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 10'h000;
    end else if (finish && !lock_q) begin
      // Offset binary to two's complement for pairs
      result_q <= {core_result[9] ^ act_q.diff, core_result[8:0]};
    end
  end

  // Result presentation follows the justify bit at once
  logic [7:0] res_lo, res_hi; // Bytes as presented to software
  always_comb begin
    if (left_justify_q) begin
      res_hi = result_q[9:2];
      res_lo = {result_q[1:0], 6'h00};
    end else begin
      res_hi = {6'h00, result_q[9:8]};
      res_lo = result_q[7:0];
    end
  end

  // Lock set by low byte read, freed by high byte read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (rd_go && araddr[7:0] == `SAC_OFF_RES_LO) begin
      lock_q <= 1'b1;
    end else if (rd_go && araddr[7:0] == `SAC_OFF_RES_HI) begin
      lock_q <= 1'b0;
    end
  end

  // Write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end
  assign awready = !aw_hold_q;
  assign wready  = !w_hold_q;

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `SAC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_addr_q[7:0] == `SAC_OFF_SELECT || aw_addr_q[7:0] == `SAC_OFF_CTRL_A ||
                   aw_addr_q[7:0] == `SAC_OFF_CTRL_B || aw_addr_q[7:0] == `SAC_OFF_RES_LO ||
                   aw_addr_q[7:0] == `SAC_OFF_RES_HI) ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end
  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;

  // Read channel; convert-go reads the busy state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `SAC_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `SAC_RESP_OKAY;
      unique case (araddr[7:0])
        `SAC_OFF_SELECT: rdata_q <= {24'h0, ref_sel_q, left_justify_q, input_select_q};
        `SAC_OFF_CTRL_A: rdata_q <= {24'h0, converter_on_q, busy, auto_trigger_on_q,
                                     done_flag_q, done_irq_on_q, clock_div_sel_q};
        `SAC_OFF_CTRL_B: rdata_q <= {29'h0, trig_src_sel_q};
        `SAC_OFF_RES_LO: rdata_q <= {24'h0, res_lo};
        `SAC_OFF_RES_HI: rdata_q <= {24'h0, res_hi};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `SAC_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign arready = !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

endmodule

// [tb/sac_core_model.sv]
// Stand-in for the analog multiplexer and converter core.
// Assumes the control block samples the code on its finish cycle.
`timescale 1ns/1ps
module sac_core_model (
  input  wire logic                 aclk,   // System clock
  input  wire sac_pkg::sac_analog_t analog, // Mux and core controls
  output logic [9:0]                code    // Offset binary code
);
  // Code follows the held channel; unpowered lines wander
  initial code = 10'h2AA;
  always @(posedge aclk) begin
    if (analog.power_on) begin
      code <= {analog.input_select, 5'h0B};
    end else begin
      code <= ~code;
    end
  end
endmodule

// [tb/sac_top_properties.sv]
// Port-level checks for the converter control block.
// Assumes it is bound into sac_top and sees its ports only.
`timescale 1ns/1ps
module sac_top_properties (
  input wire logic                 aclk,          // Clock
  input wire logic                 aresetn,       // Reset, low
  input wire logic                 arvalid,       // Read request
  input wire logic                 arready,       // Read accept
  input wire logic                 rvalid,        // Read answer
  input wire logic                 global_irq_on, // Global enable
  input wire logic                 irq_req,       // Interrupt
  input wire sac_pkg::sac_analog_t analog,        // Core controls
  input wire logic                 conv_tick,     // Converter clock
  input wire logic                 conv_start,    // Start pulse
  input wire logic                 conv_init      // First start
);
  // One domain, so one clock and reset for all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_start_on: assert property (conv_start |=> analog.power_on)
    else $error("start while off");
  chk_tick_on: assert property (conv_tick |-> analog.power_on)
    else $error("tick while off");
  chk_init_start: assert property (conv_init |-> conv_start)
    else $error("init without start");
  chk_start_gap: assert property (conv_start |=> !conv_start [*3])
    else $error("starts too close");
  chk_irq_global: assert property (irq_req |-> global_irq_on)
    else $error("interrupt without global enable");
  chk_sel_hold: assert property (
    conv_tick && !conv_start |-> $stable(analog.input_select))
    else $error("channel moved mid conversion");
  chk_ref_hold: assert property (
    conv_tick && !conv_start |-> $stable(analog.reference_sel))
    else $error("reference moved mid conversion");
  chk_gain_map: assert property (
    analog.power_on && analog.input_select[4:3] == 2'b01 |-> analog.diff &&
    analog.gain == (analog.input_select[1] ? sac_pkg::SAC_GAIN_200X : sac_pkg::SAC_GAIN_10X))
    else $error("gain mismatch");
  chk_single_map: assert property (
    analog.power_on && (analog.input_select < 5'h08 || analog.input_select > 5'h1D)
    |-> !analog.diff)
    else $error("single input shown as pair");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");

  // Main scenarios reached
  cov_first: cover property (conv_init);
  cov_irq: cover property (irq_req);
  cov_diff: cover property (conv_start && analog.diff);
endmodule

bind sac_top sac_top_properties u_props (
  .aclk, .aresetn, .arvalid, .arready, .rvalid, .global_irq_on, .irq_req, .analog,
  .conv_tick, .conv_start, .conv_init);

// [tb/tb.sv]
// Self-checking bench: registers, timing, result, triggers.
// Assumes the core model returns a code built from the channel.
`timescale 1ns/1ps
`include "sac_consts.svh"
module tb;
  logic                 aclk, aresetn;        // Clock, reset low
  logic [7:0]           awaddr, araddr;       // Addresses
  logic [31:0]          wdata, rdata;         // Data
  logic [3:0]           wstrb;                // Byte enables
  logic                 awvalid, awready;     // Write address
  logic                 wvalid, wready;       // Write data
  logic                 bvalid, bready;       // Write answer
  logic                 arvalid, arready;     // Read address
  logic                 rvalid, rready;       // Read answer
  logic [1:0]           bresp, rresp;         // Responses
  sac_pkg::sac_trig_t   trig;                 // Trigger flags
  logic                 gie, ack, irq_req;    // Interrupt path
  sac_pkg::sac_analog_t analog;               // Core controls
  logic                 tick, start, init;    // Converter pulses
  logic [9:0]           code;                 // Core result
  int                   bad_count, n_compared; // Tallies
  int                   cyc, nt, t0, t1, nst, k, m; // Bookkeeping
  logic [7:0]           d;                    // Last read byte
  logic [1:0]           r;                    // Last response
  logic [15:0]          v;                    // Result pair
  logic [4:0]           s;                    // Channel
  logic                 lj, ini;              // Justify, first seen

  sac_top DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .trig_flags(trig), .global_irq_on(gie), .irq_ack(ack), .irq_req,
    .core_result(code), .analog, .conv_tick(tick), .conv_start(start), .conv_init(init));
  sac_core_model u_core (.aclk, .analog, .code);

  // 40 MHz clock
  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  // Count ticks and starts per conversion
  always @(posedge aclk) begin
    cyc++;
    if (start) begin
      nt = 0;
      nst++;
      ini = init;
    end
    if (tick) begin
      if (nt == 0) t0 = cyc;
      t1 = cyc;
      nt++;
    end
  end

  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // A used-up bound ends the run
  task automatic lim(int n, int b);
    if (n >= b) begin
      bad_count++;
      complete_run();
    end
  endtask

  // Write: hold each channel until its ready
  task automatic wr(logic [7:0] a, logic [7:0] x);
    logic ap;
    logic wp;
    int   n;
    ap = 1;
    wp = 1;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      ap = ap && !awready;
      wp = wp && !wready;
    end while ((ap || wp) && n < 99);
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 199);
    lim(n, 199);
    r = bresp;
  endtask

  task automatic rd(logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 99);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 199);
    lim(n, 199);
    d = rdata[7:0];
    r = rresp;
  endtask

  // Low byte first, then high
  task automatic rres();
    rd(`SAC_OFF_RES_LO);
    v[7:0] = d;
    rd(`SAC_OFF_RES_HI);
    v[15:8] = d;
  endtask

  task automatic wd();
    int n;
    for (n = 0; irq_req !== 1'b1 && n < 5000; n++) @(posedge aclk);
    lim(n, 5000);
  endtask

  task automatic pulse(logic [6:0] p);
    trig <= p;
    @(posedge aclk);
    trig <= 7'h00;
    repeat (4) @(posedge aclk);
  endtask

  // Expected result bytes; pairs get the sign bit flipped
  function automatic logic [15:0] ex(logic [4:0] c, logic j);
    logic [9:0] x;
    x = {c, 5'h0B};
    x[9] = x[9] ^ (c > 5'h07 && c < 5'h1E);
    return j ? {x, 6'h00} : {6'h00, x};
  endfunction

  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, arvalid, ack, trig} = '0;
    {wstrb, bready, rready, gie} = 7'h7F;
    void'($urandom(8874));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped place
    for (k = 0; k < 5; k++) begin
      rd(8'(k * 4));
      chk(d, 8'h00);
    end
    rd(8'h14);
    chk(r, `SAC_RESP_SLVERR);
    wr(8'h14, 8'h00);
    chk(r, `SAC_RESP_SLVERR);
    wr(`SAC_OFF_CTRL_B, 8'h07);
    rd(`SAC_OFF_CTRL_B);
    chk(d, 8'h07);
    wr(`SAC_OFF_CTRL_B, 8'h00);
    // Lengths and divider for every code
    wr(`SAC_OFF_SELECT, 8'h40);
    for (k = 0; k < 8; k++) begin
      wr(`SAC_OFF_CTRL_A, 8'hD8 | 8'(k));
      chk(irq_req, 0);
      rd(`SAC_OFF_CTRL_A);
      chk(d, 8'hC8 | 8'(k));
      wd();
      chk(nt, k ? 13 : 25);
      chk(ini, k == 0);
      chk(t1 - t0, (nt - 1) * (k < 2 ? 2 : 1 << k));
    end
    // Channels: corners, then random
    for (k = 0; k < 8; k++) begin
      s = k == 0 ? 5'h1E : k == 1 ? 5'h0A : k == 2 ? 5'h1D : 5'($urandom);
      lj = 1'($urandom);
      wr(`SAC_OFF_SELECT, {2'b01, lj, s});
      wr(`SAC_OFF_CTRL_A, 8'hD8);
      wd();
      chk(analog.diff, s > 5'h07 && s < 5'h1E);
      chk(analog.gain, s[4:3] != 2'b01 ? sac_pkg::SAC_GAIN_1X : s[1] ?
        sac_pkg::SAC_GAIN_200X : sac_pkg::SAC_GAIN_10X);
      chk(analog.reference_sel, 2'b01);
      rres();
      chk(v, ex(s, lj));
      wr(`SAC_OFF_SELECT, {2'b01, !lj, s});
      rres();
      chk(v, ex(s, !lj));
    end
    // Lock across a completion, then a mid-run channel change
    rd(`SAC_OFF_RES_LO);
    wr(`SAC_OFF_SELECT, 8'h43);
    wr(`SAC_OFF_CTRL_A, 8'hD8);
    wd();
    rd(`SAC_OFF_RES_HI);
    chk(d, ex(s, 1'b0) >> 8);
    rres();
    chk(v, ex(s, 1'b0));
    wr(`SAC_OFF_CTRL_A, 8'hD8);
    wr(`SAC_OFF_SELECT, 8'h45);
    wr(`SAC_OFF_CTRL_A, 8'h88);
    rd(`SAC_OFF_CTRL_A);
    chk(d, 8'hC8);
    wd();
    chk(analog.input_select, 5'h05);
    rres();
    chk(v, ex(5'h03, 1'b0));
    // Interrupt gating and vector clear
    gie <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    chk(irq_req, 0);
    gie <= 1'b1;
    @(posedge aclk);
    ack <= 1'b1;
    @(posedge aclk);
    chk(irq_req, 1);
    ack <= 1'b0;
    @(posedge aclk);
    chk(irq_req, 0);
    // Abort by switching off
    wr(`SAC_OFF_CTRL_A, 8'hD8);
    wr(`SAC_OFF_CTRL_A, 8'h08);
    repeat (60) @(posedge aclk);
    chk(irq_req, 0);
    chk(analog.power_on, 0);
    rd(`SAC_OFF_CTRL_A);
    chk(d, 8'h08);
    // Trigger sources: auto-trigger off first, then a wrong source before each right one
    wr(`SAC_OFF_CTRL_B, 8'h01);
    wr(`SAC_OFF_CTRL_A, 8'h88);
    m = nst;
    pulse(7'h40);
    chk(nst, m);
    wr(`SAC_OFF_CTRL_A, 8'hB8);
    for (k = 1; k < 8; k++) begin
      wr(`SAC_OFF_CTRL_B, 8'(k));
      m = nst;
      pulse(7'(1 << ((8 - k) % 7)));
      chk(nst, m);
      pulse(7'(1 << (7 - k)));
      wd();
      chk(nst, m + 1);
      wr(`SAC_OFF_CTRL_A, 8'hB8);
    end
    // Reselect from a low flag to a high one
    wr(`SAC_OFF_CTRL_B, 8'h01);
    trig <= 7'h02;
    m = nst;
    wr(`SAC_OFF_CTRL_B, 8'h06);
    wd();
    chk(nst, m + 1);
    trig <= 7'h00;
    // Free running with the flag already set
    m = nst;
    wr(`SAC_OFF_CTRL_B, 8'h00);
    repeat (40) @(posedge aclk);
    chk(nst, m);
    // Auto-trigger and go raised by one write
    wr(`SAC_OFF_CTRL_A, 8'h88);
    wr(`SAC_OFF_CTRL_A, 8'hE8);
    for (k = 0; nst < m + 4 && k < 1000; k++) @(posedge aclk);
    chk(k < 1000, 1);
    wr(`SAC_OFF_CTRL_A, 8'h08);
    complete_run();
  end
endmodule
